//--- include/fec_pkg.sv
// Purpose: Shared constants and types of the erase and program controller.
// Assumes: APB byte addresses, 32-bit data, a 25 MHz system clock.
// Notes:   The array is mapped one byte per aligned APB word.
package fec_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [15:0] CTRL_OFS = 16'h0000;
    localparam logic [15:0] PROT_OFS = 16'h0004;
    localparam logic [15:0] STAT_OFS = 16'h0008;
    localparam int          ARRAY_SEL_BIT = 15;

    localparam int CTRL_PGM_BIT   = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_MASS_BIT  = 2;
    localparam int CTRL_HV_BIT    = 3;

    localparam logic [7:0] PROT_RESET  = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ---------------------------------------------------------------
    // Array geometry
    // ---------------------------------------------------------------
    localparam int         ARRAY_AW     = 13;
    localparam int         ARRAY_DW     = 8;
    localparam int         PAGE_AW      = 6;
    localparam int         ROW_AW       = 5;
    localparam logic [2:0] ARRAY_MAP_HI = 3'h7;
    localparam logic [1:0] PROT_MAP_HI  = 2'h3;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_KHZ        = 25000;
    localparam int PAGE_CLEAR_US  = 1000;
    localparam int FULL_CLEAR_US  = 4000;
    localparam int PAGE_CLEAR_CYC = (PAGE_CLEAR_US * CLK_KHZ + 999) / 1000;
    localparam int FULL_CLEAR_CYC = (FULL_CLEAR_US * CLK_KHZ + 999) / 1000;
    localparam int TIMER_W        = 17;

    typedef enum logic [4:0] {
        S_IDLE    = 5'h01,
        S_SELECT  = 5'h02,
        S_CHECKED = 5'h04,
        S_LATCHED = 5'h08,
        S_WALK    = 5'h10
    } fec_seq_e;

endpackage

//--- include/fec_mem_if.sv
// Purpose: Port between the controller and its array memory.
// Assumes: One access per cycle, read data one cycle after the request.
// Notes:   A write also returns the old word on rdata.
`timescale 1ns/1ps
`default_nettype none
interface fec_mem_if #(
    parameter int AW = 13,
    parameter int DW = 8
) ();
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

//--- core/fec_nvm_array.sv
// Purpose: Byte array standing in for the non-volatile cells.
// Assumes: Single port, registered read data.
// Notes:   Contents are not touched by reset, as in real cells.
`timescale 1ns/1ps
`default_nettype none
module fec_nvm_array #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input  wire logic clk,
    fec_mem_if.mem    port
);
    if (AW < 1 || AW > 16 || DW < 1) begin : g_bad_size
        $error("Array address width must lie between 1 and 16 and data width be at least 1.");
    end

    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk) begin
        if (port.en) begin
            if (port.we) begin
                mem_q[port.addr] <= port.wdata;
            end
            rdata_q <= mem_q[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule
`default_nettype wire

//--- core/fec_flash_erase_control.sv
// Purpose: Erase and program sequencer for an 8192 x 8 non-volatile array.
// Assumes: APB slave, synchronous active-high reset, 25 MHz clock.
// Notes:   Every APB access takes one wait state; array accesses stall during an erase walk.
//
// Contract
// RQ1: High voltage can be set only with erase or program selected, after ordered steps.
// RQ2: High voltage bit on drives array high voltage and pump; off stops both.
// RQ3: Mass bit makes the erase cover the whole 8-Kbyte array.
// RQ4: Erase and program bits never both one, never set together.
// RQ5: Program bit is read/write; one selects program operation.
// RQ6: Page erase clears all 64 bytes of one page, two rows.
// RQ7: Erased bits read one; programmed bits read zero.
// RQ8: Array is 8192 bytes, erased by page, programmed by byte.
// RQ9: Software starts page erase by writing erase set, mass clear.
// RQ10: Software then reads protection register, then writes into the target page.
// RQ11: Software waits 10 us, sets high voltage, holds it 1 ms.
// RQ12: Software waits 5 us, clears high voltage, waits 1 us recovery.
// RQ13: Mass erase: set erase and mass, read protection, write any array address.
// RQ14: Mass erase holds high voltage 4 ms, then 100 us, then 1 us.
// RQ15: Software must not run from the array being changed.
// RQ16: Secured monitor mode latches mass erase by writing the protection register.
// RQ17: A protected latched target refuses high voltage for erase and program.
// RQ18: Latching write address picks the page; its data is ignored.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fec_flash_erase_control #(
    parameter int PAGE_CLEAR_CYC = fec_pkg::PAGE_CLEAR_CYC,
    parameter int FULL_CLEAR_CYC = fec_pkg::FULL_CLEAR_CYC
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             high_voltage_drive,
    output logic             charge_pump_on
);
    localparam int AW = fec_pkg::ARRAY_AW;
    localparam int TW = fec_pkg::TIMER_W;
    localparam logic [TW-1:0] PAGE_LIM = TW'(PAGE_CLEAR_CYC);
    localparam logic [TW-1:0] FULL_LIM = TW'(FULL_CLEAR_CYC);

    if (PAGE_CLEAR_CYC < 1 || FULL_CLEAR_CYC < 1 || FULL_CLEAR_CYC >= (1 << TW) ||
        PAGE_CLEAR_CYC >= (1 << TW)) begin : g_bad_timing
        $error("Erase cycle counts must lie between 1 and the timer range.");
    end

    // Protected when the boundary is not at its reset value and the array byte lies at or above the boundary start address.
    function automatic logic in_protected(input logic [AW-1:0] idx, input logic [7:0] bpr);
        logic [15:0] a;
        logic [15:0] start;
        a     = {fec_pkg::ARRAY_MAP_HI, idx};
        start = {fec_pkg::PROT_MAP_HI, bpr, 6'h00};
        return (bpr != fec_pkg::PROT_RESET) && (a >= start);
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    fec_pkg::fec_seq_e seq_q, seq_d;
    logic          ph_q;
    logic          pgm_q, erase_q, mass_q, hv_q;
    logic [7:0]    bpr_q;
    logic [AW-1:0] lat_idx_q;
    logic [AW-1:0] walk_idx_q;
    logic          walk_mass_q;
    logic [TW-1:0] timer_q;
    logic [31:0]   rd_q;

    fec_mem_if #(.AW(AW), .DW(fec_pkg::ARRAY_DW)) mem_bus ();

    // The memory sits behind its own port so that its read data always come from a flop.
    fec_nvm_array #(.AW(AW), .DW(fec_pkg::ARRAY_DW)) u_array (
        .clk  (clk),
        .port (mem_bus.mem)
    );

    // ---------------------------------------------------------------
    // Bus decode
    // ---------------------------------------------------------------
    wire           access  = psel & penable;
    wire           is_arr  = paddr[fec_pkg::ARRAY_SEL_BIT];
    wire [AW-1:0]  arr_idx = paddr[AW+1:2];
    wire           is_ctrl = paddr == fec_pkg::CTRL_OFS;
    wire           is_prot = paddr == fec_pkg::PROT_OFS;
    wire           is_stat = paddr == fec_pkg::STAT_OFS;
    // Only offsets on the map answer without error; anything else is refused with pslverr.
    wire           mapped  = is_arr | is_ctrl | is_prot | is_stat;
    wire           walking = seq_q == fec_pkg::S_WALK;
    // The first cycle of an array access may not advance while the erase walk owns the array.
    wire           first   = access & ~ph_q & ~(is_arr & walking);
    wire           done    = access & ph_q;
    wire           ctl_wr  = done & pwrite & is_ctrl;
    wire           prot_rd = done & ~pwrite & is_prot;
    wire           prot_wr = done & pwrite & is_prot;
    wire           arr_wr  = done & pwrite & is_arr;

    // ---------------------------------------------------------------
    // Control register write decode
    // ---------------------------------------------------------------
    wire w_pgm   = pwdata[fec_pkg::CTRL_PGM_BIT];
    wire w_erase = pwdata[fec_pkg::CTRL_ERASE_BIT];
    wire w_mass  = pwdata[fec_pkg::CTRL_MASS_BIT];
    wire w_hv    = pwdata[fec_pkg::CTRL_HV_BIT];
    // A write asking for both operations is dropped for both bits. [RQ4]
    wire both_req  = w_pgm & w_erase;
    wire new_erase = both_req ? erase_q : w_erase;
    wire new_pgm   = both_req ? pgm_q : w_pgm;
    wire new_op    = new_erase | new_pgm;

    // A mass erase is blocked by any protection at all, a page or row by its own address. [RQ17]
    wire prot_hit  = (erase_q & mass_q) ? (bpr_q != fec_pkg::PROT_RESET) : in_protected(lat_idx_q, bpr_q);
    wire hv_ok     = new_op & (seq_q == fec_pkg::S_LATCHED) & ~prot_hit;  // [RQ1] [RQ17]
    // Once on, high voltage stays on until software clears it, whatever the state.
    wire new_hv    = w_hv & (hv_q | hv_ok);                               // [RQ1]

    wire time_met  = timer_q >= (mass_q ? FULL_LIM : PAGE_LIM);
    // Erase only lands when high voltage was held for the full time before erase drops.
    wire commit    = ctl_wr & erase_q & ~new_erase & hv_q & time_met & (seq_q == fec_pkg::S_LATCHED);
    wire latch_ev  = (seq_q == fec_pkg::S_CHECKED) &
                     (arr_wr | (prot_wr & erase_q & mass_q));              // [RQ16] [RQ18]
    wire walk_last = walk_mass_q ? (walk_idx_q == {AW{1'b1}})
                                 : (walk_idx_q[fec_pkg::PAGE_AW-1:0] == {fec_pkg::PAGE_AW{1'b1}});
    wire [AW-1:0] walk_base = mass_q ? {AW{1'b0}}
                                     : {lat_idx_q[AW-1:fec_pkg::PAGE_AW], {fec_pkg::PAGE_AW{1'b0}}}; // [RQ3] [RQ6]
    // Programming only clears bits inside the latched row. [RQ7] [RQ8]
    wire prog_wr   = arr_wr & pgm_q & hv_q & (seq_q == fec_pkg::S_LATCHED) & ~prot_hit &
                     (arr_idx[AW-1:fec_pkg::ROW_AW] == lat_idx_q[AW-1:fec_pkg::ROW_AW]);

    // ---------------------------------------------------------------
    // Sequence tracking
    // ---------------------------------------------------------------
    // A commit outranks every other event, and a walk is never cut short by software.
    always_comb begin
        seq_d = seq_q;
        unique case (seq_q)
            fec_pkg::S_WALK: begin
                if (walk_last) begin
                    seq_d = fec_pkg::S_IDLE;
                end
            end
            fec_pkg::S_IDLE, fec_pkg::S_SELECT, fec_pkg::S_CHECKED, fec_pkg::S_LATCHED: begin
                if (commit) begin
                    seq_d = fec_pkg::S_WALK;
                end else if (ctl_wr) begin
                    if (!new_op) begin
                        seq_d = fec_pkg::S_IDLE;
                    end else if (seq_q == fec_pkg::S_IDLE || new_erase != erase_q) begin
                        seq_d = fec_pkg::S_SELECT;
                    end
                end else if (prot_rd && seq_q == fec_pkg::S_SELECT) begin
                    seq_d = fec_pkg::S_CHECKED;
                end else if (latch_ev) begin
                    seq_d = fec_pkg::S_LATCHED;
                end
            end
            default: seq_d = fec_pkg::S_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // Read mux and array port
    // ---------------------------------------------------------------
    // Register reads are captured in the first access cycle; array reads come
    // straight from the memory's output flop, which holds them for the answer cycle.
    wire [31:0] reg_rd = is_ctrl ? {28'h0, hv_q, mass_q, erase_q, pgm_q} :
                         is_prot ? {24'h0, bpr_q} :
                         is_stat ? {26'h0, time_met, seq_q} : 32'h0;

    // The erase walk owns the array port; bus accesses to the array stall until it ends.
    assign mem_bus.en    = walking | (first & is_arr) | prog_wr;
    assign mem_bus.we    = walking | prog_wr;
    assign mem_bus.addr  = walking ? walk_idx_q : arr_idx;
    assign mem_bus.wdata = walking ? fec_pkg::ERASED_BYTE : (mem_bus.rdata & pwdata[7:0]); // [RQ7]

    assign pready  = ph_q;
    assign pslverr = ph_q & ~mapped;
    assign prdata  = is_arr ? {24'h0, mem_bus.rdata} : rd_q;

    // High voltage and the pump follow the enable bit directly. [RQ2]
    assign high_voltage_drive = hv_q;
    assign charge_pump_on     = hv_q;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_q   <= fec_pkg::S_IDLE;
            ph_q    <= 1'b0;
            pgm_q   <= 1'b0;
            erase_q <= 1'b0;
            mass_q  <= 1'b0;
            hv_q    <= 1'b0;
            rd_q    <= 32'h0;
        end else begin
            seq_q <= seq_d;
            // The answer phase lasts one cycle; pready rises in the second access cycle.
            ph_q  <= first;
            if (first) begin
                rd_q <= reg_rd;
            end
            if (ctl_wr) begin
                pgm_q   <= new_pgm;   // [RQ5] [RQ4]
                erase_q <= new_erase; // [RQ4]
                mass_q  <= w_mass;    // [RQ3]
                hv_q    <= new_hv;    // [RQ1]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bpr_q       <= fec_pkg::PROT_RESET;
            lat_idx_q   <= {AW{1'b0}};
            walk_idx_q  <= {AW{1'b0}};
            walk_mass_q <= 1'b0;
            timer_q     <= {TW{1'b0}};
        end else begin
            // The boundary is frozen outside IDLE so that a running sequence cannot
            // move the protected range under its own latched target.
            if (prot_wr && seq_q == fec_pkg::S_IDLE) begin
                bpr_q <= pwdata[7:0];
            end
            if (latch_ev && arr_wr) begin
                lat_idx_q <= arr_idx; // [RQ18]
            end
            if (commit) begin
                walk_idx_q  <= walk_base;
                walk_mass_q <= mass_q;
            end else if (walking) begin
                walk_idx_q <= walk_idx_q + 1'b1; // [RQ6] [RQ3]
            end
            // The hold timer runs only while erase and high voltage are both on, and
            // saturates at the limit so that a long software hold never wraps it.
            if (!(hv_q && erase_q)) begin
                timer_q <= {TW{1'b0}};
            end else if (!time_met) begin
                timer_q <= timer_q + 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_commit;
        ctl_wr && commit;
    endsequence
    sequence s_walk_page;
        walking && mem_bus.we && mem_bus.wdata == 8'hFF;
    endsequence
    sequence s_walk_mid;
        walking && !walk_last;
    endsequence

    a_hv_set_order: assert property ($rose(hv_q) |-> (erase_q || pgm_q) && $past(seq_q) == fec_pkg::S_LATCHED) // [RQ1]
        else $error("High voltage rose outside the latched state.");
    a_hv_pump_off: assert property (ctl_wr && !w_hv |=> !charge_pump_on && !high_voltage_drive) // [RQ2]
        else $error("Pump or high voltage still on after the enable bit was cleared.");
    a_op_interlock: assert property (!(erase_q && pgm_q)) // [RQ4]
        else $error("Erase and program selected together.");
    a_pgm_write_rw: assert property (ctl_wr && pwdata[1:0] == 2'b01 |=> pgm_q && !erase_q) // [RQ5]
        else $error("Program select did not follow its write.");
    a_page_walk_len: assert property (s_commit ##0 !mass_q |=> s_walk_page [*8]) // [RQ6]
        else $error("Page erase walk broke off early.");
    a_mass_walk_base: assert property (s_commit ##0 mass_q |=> walking && walk_idx_q == 13'h0000) // [RQ3]
        else $error("Mass erase did not start at the first byte.");
    a_erase_ones: assert property (walking |-> mem_bus.we && mem_bus.wdata == 8'hFF) // [RQ7]
        else $error("Erase walk wrote a value other than all ones.");
    a_array_wait: assert property (access && is_arr && !ph_q && !walking |=> pready && !pslverr) // [RQ8]
        else $error("Array access did not answer after one wait state.");
    a_prot_refuse: assert property (ctl_wr && prot_hit && !hv_q |=> !hv_q) // [RQ17]
        else $error("High voltage set over a protected target.");
    a_latch_addr: assert property (latch_ev && arr_wr |=> lat_idx_q == $past(arr_idx)) // [RQ18]
        else $error("Latched index differs from the latching write address.");

    a_both_refused: assert property (ctl_wr && both_req |=> $stable(pgm_q) && $stable(erase_q)) // [RQ4]
        else $error("A write asking for both operations changed the selection.");
    // Together these pin a page walk to consecutive writes that stay inside one page and end on its last byte.
    a_page_bounds: assert property (walking && !walk_mass_q |-> // [RQ6]
        walk_idx_q[AW-1:fec_pkg::PAGE_AW] == lat_idx_q[AW-1:fec_pkg::PAGE_AW])
        else $error("Page erase walked outside the latched page.");
    a_walk_step: assert property (s_walk_mid |=> // [RQ3] [RQ6]
        walking && walk_idx_q == $past(walk_idx_q) + 1'b1)
        else $error("Erase walk skipped or repeated a byte.");
    a_walk_ends: assert property (walking && walk_last |=> !walking && seq_q == fec_pkg::S_IDLE) // [RQ6]
        else $error("Erase walk ran past its last byte.");
    a_write_gated: assert property (mem_bus.we && !walking |-> pgm_q && hv_q && !prot_hit) // [RQ8] [RQ17]
        else $error("Array written outside a valid program step.");
    a_prog_clears_only: assert property (prog_wr |-> (mem_bus.wdata | mem_bus.rdata) == mem_bus.rdata) // [RQ7]
        else $error("Programming set a bit that was clear.");
    a_hv_latched_only: assert property (ctl_wr && w_hv && !hv_q && seq_q != fec_pkg::S_LATCHED |=> !hv_q) // [RQ1]
        else $error("High voltage set outside the latched state.");
endmodule
`default_nettype wire

//--- dv/fec_cpu_model.sv
// Purpose: Processor-side APB master that runs the erase and program software.
// Assumes: One transfer at a time, issued by the bench through xfer.
// Notes: Code runs from the bench, never from the array it changes.
`timescale 1ns/1ps
`default_nettype none
module fec_cpu_model (
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [15:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 16'h0000;
        pwdata <= 32'h0;
    end

    // -----------------------------------------------------------
    // Bus transfer
    // -----------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released bus carries no stale value the slave could lean on.
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

//--- dv/tb_flash_erase_control.sv
// Purpose: Self-checking bench for the erase and program controller.
// Assumes: 25 MHz clock, short hold counts set through parameters.
// Notes:   Software waits are counted in cycles of 40 ns.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_erase_control;
    localparam int PCYC = 20;
    localparam int FCYC = 40;
    logic        clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        pready;
    logic        pslverr;
    logic        hv;
    logic        pump;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    int          miscompares = 0;
    int          n_checks = 0;
    int          tmo = 0;

    fec_flash_erase_control #(.PAGE_CLEAR_CYC(PCYC), .FULL_CLEAR_CYC(FCYC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .high_voltage_drive(hv), .charge_pump_on(pump));

    fec_cpu_model u_cpu (
        .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // -----------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        u_cpu.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        u_cpu.xfer(1'b0, a, 32'h0, q, e);
        chk(nm, q, exp);
    endtask

    task automatic pins(input logic e);
        cyc(2);
        chk("hv_pins", {30'h0, hv, pump}, {30'h0, e, e});
    endtask

    function automatic logic [15:0] aa(input int i);
        return 16'h8000 + 16'(i * 4);
    endfunction

    task automatic erase(input logic mass, input logic [15:0] latch);
        wr(fec_pkg::CTRL_OFS, {29'h0, mass, 2'b10});
        rdc("prot", fec_pkg::PROT_OFS, 32'hFF);
        wr(latch, 32'h5A);
        cyc(250);
        wr(fec_pkg::CTRL_OFS, {28'h0, 1'b1, mass, 2'b10});
        pins(1'b1);
        cyc((mass ? FCYC : PCYC) + 4);
        wr(fec_pkg::CTRL_OFS, {28'h0, 1'b1, mass, 2'b00});
        // The walk over the whole array outlasts the 100 us wait that software must keep.
        cyc(mass ? 8300 : 125);
        wr(fec_pkg::CTRL_OFS, 32'h0);
        pins(1'b0);
        cyc(25);
    endtask

    task automatic prog(input int i, input logic [7:0] d);
        wr(fec_pkg::CTRL_OFS, 32'h1);
        rdc("prot", fec_pkg::PROT_OFS, 32'hFF);
        wr(aa(i), 32'hFF);
        cyc(250);
        wr(fec_pkg::CTRL_OFS, 32'h9);
        cyc(125);
        wr(aa(i), {24'h0, d});
        cyc(750);
        wr(fec_pkg::CTRL_OFS, 32'h8);
        cyc(125);
        wr(fec_pkg::CTRL_OFS, 32'h0);
        cyc(25);
    endtask

    // -----------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h0);
        rdc("prot", fec_pkg::PROT_OFS, 32'hFF);
        rdc("stat", fec_pkg::STAT_OFS, 32'h01);
        u_cpu.xfer(1'b0, 16'h000C, 32'h0, q, e);
        chk("unmapped", {q[30:0], e}, 32'h1);
    endtask

    task automatic t_interlock();
        wr(fec_pkg::CTRL_OFS, 32'h8);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h0);
        pins(1'b0);
        wr(fec_pkg::CTRL_OFS, 32'h3);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h0);
        wr(fec_pkg::CTRL_OFS, 32'h1);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h1);
        wr(fec_pkg::CTRL_OFS, 32'h3);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h1);
        wr(fec_pkg::CTRL_OFS, 32'h0);
        rdc("stat", fec_pkg::STAT_OFS, 32'h01);
    endtask

    task automatic t_mass();
        erase(1'b1, aa(5));
        rdc("a0", aa(0), 32'hFF);
        rdc("a4095", aa(4095), 32'hFF);
        rdc("a8191", aa(8191), 32'hFF);
    endtask

    task automatic t_page();
        prog(64, 8'h00);
        prog(127, 8'h3C);
        prog(128, 8'hA5);
        rdc("a64", aa(64), 32'h00);
        rdc("a127", aa(127), 32'h3C);
        erase(1'b0, aa(100));
        rdc("a64", aa(64), 32'hFF);
        rdc("a127", aa(127), 32'hFF);
        rdc("a128", aa(128), 32'hA5);
    endtask

    task automatic t_protect();
        wr(fec_pkg::PROT_OFS, 32'hFE);
        rdc("prot", fec_pkg::PROT_OFS, 32'hFE);
        wr(fec_pkg::CTRL_OFS, 32'h1);
        rdc("prot", fec_pkg::PROT_OFS, 32'hFE);
        wr(aa(8064), 32'h0);
        wr(fec_pkg::CTRL_OFS, 32'h9);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h1);
        pins(1'b0);
        wr(fec_pkg::CTRL_OFS, 32'h6);
        rdc("prot", fec_pkg::PROT_OFS, 32'hFE);
        wr(aa(0), 32'h0);
        wr(fec_pkg::CTRL_OFS, 32'hE);
        rdc("ctrl", fec_pkg::CTRL_OFS, 32'h6);
        wr(fec_pkg::CTRL_OFS, 32'h0);
        wr(fec_pkg::PROT_OFS, 32'hFF);
    endtask

    task automatic t_monitor();
        erase(1'b1, fec_pkg::PROT_OFS);
        rdc("a128", aa(128), 32'hFF);
    endtask

    always @(posedge clk) begin
        tmo++;
        if (tmo == 60000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        sys_rst = 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_interlock();
        t_mass();
        t_page();
        t_protect();
        t_monitor();
        end_of_test();
    end
endmodule
`default_nettype wire
